/* design/pfbc_pkg.sv */
// Purpose: shared constants for the parallel flash bus controller
// Assumes: 200 MHz pclk, APB slave register port
// Notes:   timing figures in ns, cycle counts derived from them
package pfbc_pkg;
   // clock
   localparam int unsigned CLK_PERIOD_NS = 5;
   // flash timing figures (ns), plain defaults
   localparam int unsigned ADDRESS_ACCESS_TIME_NS   = 70;
   localparam int unsigned WRITE_PULSE_NS           = 35;
   localparam int unsigned WRITE_HIGH_NS            = 30;
   localparam int unsigned RESET_PULSE_MIN_WIDTH_NS = 500;
   localparam int unsigned RESET_HIGH_TO_READ_NS    = 50;
   // least times round up
   localparam int unsigned ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WP_CYC  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WPH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RP_CYC  = (RESET_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RH_CYC  = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_SECTOR = 8'h14;
   // ctrl fields
   localparam int unsigned CTRL_GO    = 0;
   localparam int unsigned CTRL_WRITE = 1;
   localparam int unsigned CTRL_RESET = 2;
   localparam int unsigned CTRL_WORD  = 3;
   localparam int unsigned CTRL_TOPB  = 4;
   // status fields
   localparam int unsigned STAT_BUSY  = 0;
   localparam int unsigned STAT_RDY   = 1;
   localparam int unsigned STAT_CWORD = 2;
   localparam int unsigned STAT_CNT   = 8;
   // ctrl reset value: word mode, top boot
   localparam logic [4:0] CTRL_RST = 5'h18;
   // sector decode patterns
   localparam logic [2:0] SEC_ALL_ONE  = 3'h7;
   localparam logic [2:0] SEC_ALL_ZERO = 3'h0;
   typedef enum logic [2:0] {
      PFBC_IDLE  = 3'b000,
      PFBC_SETUP = 3'b001,
      PFBC_READ  = 3'b010,
      PFBC_WRLO  = 3'b011,
      PFBC_WRHI  = 3'b100,
      PFBC_RSTLO = 3'b101,
      PFBC_RSTHI = 3'b110
   } pfbc_state_type;
endpackage : pfbc_pkg

/* design/pfbc_sync.sv */
// Purpose: two flop synchroniser for one pin level
// Assumes: input from outside the pclk domain
// Notes:   first flop read only by the second
`timescale 1ns/100ps
`default_nettype none
module pfbc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta_ff; // first stage
   // two stage capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= RST_VAL;
         dout    <= RST_VAL;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule : pfbc_sync
`default_nettype wire

/* design/pfbc_ctrl.sv */
// Purpose: host controller driving a parallel flash through its pins
// Assumes: APB slave for orders; flash pins asynchronous to pclk
// Notes:   one access at a time; software issues command sequences
//
// How it works
// - read: chip and output enable low, write high
// - write: write and chip enable low, output high
// - bypass program needs two writes, not four
// - software restarts operations cut by reset
// - wait recovery time after reset before read
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pfbc_ctrl
   import pfbc_pkg::*;
#(
   parameter int unsigned ADDR_W = 18
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // flash control pins
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_reset_n,
   output logic             flash_byte_n,
   output logic [ADDR_W-1:0] flash_addr,
   // flash data lines, three signals each
   input  wire logic [15:0] data_lines_i,
   output logic [15:0]      data_lines_o,
   output logic [15:0]      data_lines_oe,
   // ready busy from flash
   input  wire logic        ready_busy_n
);
   // sector decode is fixed to an 18 bit word address, refuse anything else
   if (ADDR_W != 18) begin : g_bad_addr_w
      $error("pfbc_ctrl: address decode needs 18 bits");
   end

   pfbc_state_type state_ff;           // access sequencer
   logic [9:0]     cnt_ff;             // phase timer
   logic [4:0]     ctrl_ff;            // mode bits
   logic [ADDR_W:0] addr_ff;           // address incl. A-1 at bit 0
   logic [15:0]    wdata_ff;           // write data
   logic [15:0]    rdata_ff;           // captured read data
   logic [15:0]    done_cnt_ff;        // completed accesses
   logic [15:0]    dq_s;               // synchronised data lines
   logic           rb_s;               // synchronised ready busy
   logic           go;                 // start strobe from apb
   logic           wr_acc;             // apb write access phase
   logic [3:0]     sector;             // decoded sector number
   logic [2:0]     hi3;                // address bits 17..15
   logic           word_m;             // word configuration

   // synchronise every flash pin input
   for (genvar i = 0; i < 16; i++) begin : g_dq
      pfbc_sync #(.RST_VAL(1'b0)) u_dq (
         .pclk(pclk), .presetn(presetn), .din(data_lines_i[i]), .dout(dq_s[i]));
   end
   pfbc_sync #(.RST_VAL(1'b1)) u_rb (
      .pclk(pclk), .presetn(presetn), .din(ready_busy_n), .dout(rb_s));

   assign wr_acc = psel & penable & pwrite;
   assign go     = wr_acc && paddr == REG_CTRL && pwdata[CTRL_GO];
   assign word_m = ctrl_ff[CTRL_WORD];

   // sector decode, word address bits 17..12 at addr_ff[18:13]
   assign hi3 = addr_ff[18:16];
   always_comb begin
      sector = 4'h0;
      if (ctrl_ff[CTRL_TOPB]) begin
         if (hi3 != SEC_ALL_ONE)        sector = {1'b0, hi3};
         else if (!addr_ff[15])         sector = 4'h7;
         else if (!addr_ff[14])         sector = addr_ff[13] ? 4'h9 : 4'h8;
         else                           sector = 4'hA;
      end else begin
         if (hi3 != SEC_ALL_ZERO)       sector = {1'b0, hi3} + 4'h3;
         else if (addr_ff[15])          sector = 4'h3;
         else if (addr_ff[14])          sector = addr_ff[13] ? 4'h2 : 4'h1;
         else                           sector = 4'h0;
      end
   end

   // apb never stalls; unmapped reads zero without error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end
   end

   // software registers; writes refused while an access runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff  <= CTRL_RST;
         addr_ff  <= '0;
         wdata_ff <= 16'h0000;
      end else if (wr_acc && state_ff == PFBC_IDLE) begin
         unique case (paddr)
            REG_CTRL:  ctrl_ff  <= pwdata[4:0];
            REG_ADDR:  addr_ff  <= pwdata[ADDR_W:0];
            REG_WDATA: wdata_ff <= pwdata[15:0];
            default:   ;
         endcase
      end
   end

   // read mux
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            REG_CTRL:   prdata <= {27'h0, ctrl_ff};
            REG_ADDR:   prdata <= {13'h0, addr_ff};
            REG_WDATA:  prdata <= {16'h0, wdata_ff};
            REG_RDATA:  prdata <= {16'h0, rdata_ff};
            // done count sits at STAT_CNT, flags in the low bits
            REG_STATUS: prdata <= {8'h00, done_cnt_ff, 5'h00, word_m, rb_s,
                                   state_ff != PFBC_IDLE};
            REG_SECTOR: prdata <= {28'h0, sector};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // access sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= PFBC_IDLE;
         cnt_ff      <= '0;
         done_cnt_ff <= 16'h0000;
         rdata_ff    <= 16'h0000;
      end else begin
         unique case (state_ff)
            PFBC_IDLE: if (go) begin
               cnt_ff   <= 10'(ACC_CYC);
               state_ff <= pwdata[CTRL_RESET] ? PFBC_RSTLO
                         : pwdata[CTRL_WRITE] ? PFBC_SETUP : PFBC_READ;
               if (pwdata[CTRL_RESET]) cnt_ff <= 10'(RP_CYC);
               // one go gives one bus write cycle; bypass program is two gos
               if (pwdata[CTRL_WRITE]) cnt_ff <= 10'(WPH_CYC);
            end
            PFBC_SETUP: if (cnt_ff == 0) begin  // address setup before strobe
               state_ff <= PFBC_WRLO;
               cnt_ff   <= 10'(WP_CYC);
            end else cnt_ff <= cnt_ff - 10'd1;
            PFBC_READ: if (cnt_ff == 0) begin
               rdata_ff    <= word_m ? dq_s : {8'h00, dq_s[7:0]};
               done_cnt_ff <= done_cnt_ff + 16'd1;
               state_ff    <= PFBC_IDLE;
            end else cnt_ff <= cnt_ff - 10'd1;
            PFBC_WRLO: if (cnt_ff == 0) begin
               state_ff <= PFBC_WRHI;
               cnt_ff   <= 10'(WPH_CYC);
            end else cnt_ff <= cnt_ff - 10'd1;
            PFBC_WRHI: if (cnt_ff == 0) begin
               done_cnt_ff <= done_cnt_ff + 16'd1;
               state_ff    <= PFBC_IDLE;
            end else cnt_ff <= cnt_ff - 10'd1;
            PFBC_RSTLO: if (cnt_ff == 0) begin
               state_ff <= PFBC_RSTHI;
               cnt_ff   <= 10'(RH_CYC);
            end else cnt_ff <= cnt_ff - 10'd1;
            // idle only once the flash can take a restarted command
            PFBC_RSTHI: if (cnt_ff == 0 && rb_s) begin
               done_cnt_ff <= done_cnt_ff + 16'd1;
               state_ff    <= PFBC_IDLE;
            end else if (cnt_ff != 0) cnt_ff <= cnt_ff - 10'd1;
            default: state_ff <= PFBC_IDLE;
         endcase
      end
   end

   // pin drive, registered from state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_reset_n <= 1'b1;
         flash_byte_n  <= 1'b1;
         flash_addr    <= '0;
         data_lines_o  <= 16'h0000;
         data_lines_oe <= 16'h0000;
      end else begin
         // address held after access lets flash sleep
         flash_addr    <= addr_ff[ADDR_W:1];
         flash_byte_n  <= word_m;
         // chip enable spans write high too, so the strobe rise latches data
         flash_ce_n    <= !(state_ff inside {PFBC_READ, PFBC_SETUP, PFBC_WRLO,
                                             PFBC_WRHI});
         flash_oe_n    <= state_ff != PFBC_READ;
         flash_we_n    <= state_ff != PFBC_WRLO;
         flash_reset_n <= state_ff != PFBC_RSTLO;
         // write data: word or byte, top line carries A-1 in byte mode
         data_lines_o  <= word_m ? wdata_ff : {addr_ff[0], 7'h00, wdata_ff[7:0]};
         if (state_ff inside {PFBC_SETUP, PFBC_WRLO, PFBC_WRHI})
            data_lines_oe <= word_m ? 16'hFFFF : 16'h80FF;
         else
            data_lines_oe <= word_m ? 16'h0000 : 16'h8000;
      end
   end
endmodule : pfbc_ctrl
`default_nettype wire

/* sim/pfbc_flash_model.sv */
// Purpose: behavioural flash on the controller's far side
// Assumes: small array, address wraps at 16 words
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module pfbc_flash_model (
   // strobes
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        reset_n,
   input  wire logic        byte_n,
   // address and data
   input  wire logic [17:0] addr,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic             rb_n
);
   logic [15:0] mem [16];         // array words
   logic        busy = 1'b0;      // embedded operation running
   logic        poll = 1'b0;      // inverted data bit 7
   logic [15:0] last = 16'h0000;  // last value driven
   wire  [3:0]  wa   = addr[3:0];
   wire  [15:0] wv   = mem[wa];
   wire         rd_en = !ce_n && !oe_n && we_n && reset_n;
   // status reads share the normal read path
   wire  [15:0] rv   = busy ? {8'h00, poll, 7'h00} :
      (byte_n ? wv : {8'h00, dq_in[15] ? wv[15:8] : wv[7:0]});
   // held output while address rests
   always @* if (rd_en) last = rv;
   assign dq_out = rd_en ? rv : ~last;
   assign rb_n   = !busy;
   // erased array readable with no command
   initial foreach (mem[i]) mem[i] = 16'hFFFF;
   // program taken on the rising write strobe
   always @(posedge we_n) if (!ce_n && oe_n && reset_n && !busy) begin
      if (byte_n) mem[wa] = dq_in;
      else if (dq_in[15]) mem[wa][15:8] = dq_in[7:0];
      else mem[wa][7:0] = dq_in[7:0];
      poll = ~dq_in[7];
      busy = 1'b1;
   end
   // runs to the end whatever chip enable does
   always @(posedge busy) #600 busy = 1'b0;
   // reset aborts, busy stays high a short while
   always @(negedge reset_n) #20 busy = 1'b0;
endmodule : pfbc_flash_model
`default_nettype wire

/* sim/pfbc_ctrl_sva.sv */
// Purpose: pin-level checks of the flash controller
// Assumes: pclk domain only
// Notes:   counters measure reset pulse and recovery
`timescale 1ns/100ps
`default_nettype none
module pfbc_ctrl_chk
   import pfbc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // flash pins
   input  wire logic        flash_ce_n,
   input  wire logic        flash_oe_n,
   input  wire logic        flash_we_n,
   input  wire logic        flash_reset_n,
   input  wire logic        flash_byte_n,
   input  wire logic [15:0] data_lines_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] lo_cnt_ff;  // cycles with flash reset low
   logic [7:0] hi_cnt_ff;  // cycles since flash reset rose, saturating
   // counters, not asserted directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_cnt_ff <= 8'h00;
      else lo_cnt_ff <= flash_reset_n ? 8'h00 : lo_cnt_ff + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_cnt_ff <= 8'hFF;
      else if (!flash_reset_n) hi_cnt_ff <= 8'h00;
      else if (hi_cnt_ff != 8'hFF) hi_cnt_ff <= hi_cnt_ff + 8'h01;
   end
   read_strobes_a: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n)
      else $error("read strobes wrong");
   write_strobes_a: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
      else $error("write strobes wrong");
   write_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*7])
      else $error("write pulse short");
   write_drive_a: assert property (!flash_we_n |->
      &data_lines_oe[7:0] && (!flash_byte_n || &data_lines_oe[15:8]))
      else $error("write data not driven");
   read_float_a: assert property (!flash_oe_n |->
      data_lines_oe[14:0] == 15'h0000 && (!flash_byte_n || !data_lines_oe[15]))
      else $error("driving during read");
   byte_lines_a: assert property (!flash_byte_n |->
      data_lines_oe[14:8] == 7'h00 && data_lines_oe[15])
      else $error("byte mode lines wrong");
   reset_width_a: assert property ($rose(flash_reset_n) |-> lo_cnt_ff >= RP_CYC)
      else $error("reset pulse short");
   reset_quiet_a: assert property (!flash_reset_n |-> flash_ce_n && flash_we_n)
      else $error("access during reset");
   reset_recovery_a: assert property ($fell(flash_oe_n) |-> hi_cnt_ff >= RH_CYC)
      else $error("read too soon after reset");
   cover property ($rose(flash_reset_n));
   cover property ($fell(flash_we_n) && !flash_byte_n);
   cover property ($fell(flash_oe_n) && flash_byte_n);
endmodule : pfbc_ctrl_chk
bind pfbc_ctrl pfbc_ctrl_chk pfbc_ctrl_chk_i (.pclk(pclk), .presetn(presetn),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n), .data_lines_oe(data_lines_oe));
`default_nettype wire

/* sim/tb.sv */
// Purpose: self-checking bench of the flash controller
// Assumes: flash model on the pins, APB tasks below
// Notes:   reset abort runs last
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pfbc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, ce_n, oe_n, we_n, rst_n, byte_n, rb_n;
   logic [17:0] faddr;
   logic [15:0] d_o, d_oe, m_dq;
   wire  [15:0] d_i = (d_oe & d_o) | (~d_oe & m_dq); // wire level
   int          fails = 0, checks_done = 0;
   int          we_cnt = 0, n0 = 0, w0 = 0; // strobe count, saved counts
   localparam logic [9:0] SEC [10] = '{10'h3C8, 10'h3D9, 10'h3EA, 10'h3B7, 10'h376,
      10'h010, 10'h021, 10'h032, 10'h073, 10'h084}; // address bits, sector
   always #2.5 pclk = ~pclk;
   always @(negedge we_n) we_cnt++; // write strobes seen at the pins
   pfbc_ctrl pfbc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_reset_n(rst_n), .flash_byte_n(byte_n), .flash_addr(faddr),
      .data_lines_i(d_i), .data_lines_o(d_o), .data_lines_oe(d_oe), .ready_busy_n(rb_n));
   pfbc_flash_model pfbc_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_n(rst_n), .byte_n(byte_n), .addr(faddr), .dq_in(d_i), .dq_out(m_dq),
      .rb_n(rb_n));
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // one apb transfer, read data left in rd
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task poll(input int b, input logic v);
      int i;
      for (i = 0; i < 400; i++) begin
         apb(1'b0, REG_STATUS, 32'h0);
         if (rd[b] === v) break;
      end
      if (i == 400) begin
         fails++;
         $display("wrong value status bit %0d expected %b seen %b", b, v, rd[b]);
      end
   endtask : poll
   // one flash access, then RDATA read back
   task op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
      apb(1'b1, REG_ADDR, a);
      apb(1'b1, REG_WDATA, d);
      apb(1'b1, REG_CTRL, c);
      poll(STAT_BUSY, 1'b0);
      apb(1'b0, REG_RDATA, 32'h0);
   endtask : op
   task t_blank;
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", 32'h18, rd & 32'h1F);
      op(32'h8, 32'h0, 32'h19);
      chk("blank", 32'hFFFF, rd & 32'hFFFF);
   endtask : t_blank
   task t_word;
      apb(1'b0, REG_STATUS, 32'h0);
      n0 = rd[STAT_CNT +: 16];
      w0 = we_cnt;
      op(32'h6, 32'h1234, 32'h1B);
      chk("write pulses", w0 + 1, we_cnt);
      op(32'h6, 32'h0, 32'h19);
      chk("status", 32'h0080, rd & 32'hFFFF);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("done count", n0 + 2, {16'h0, rd[STAT_CNT +: 16]});
      poll(STAT_RDY, 1'b1);
      op(32'h6, 32'h0, 32'h19);
      chk("word", 32'h1234, rd & 32'hFFFF);
   endtask : t_word
   task t_byte;
      op(32'hB, 32'hA5, 32'h13);
      poll(STAT_RDY, 1'b1);
      op(32'hB, 32'h0, 32'h11);
      chk("byte hi", 32'hA5, rd & 32'hFF);
      op(32'hA, 32'h0, 32'h11);
      chk("byte lo", 32'hFF, rd & 32'hFF);
   endtask : t_byte
   task t_sector;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, REG_CTRL, i < 5 ? 32'h18 : 32'h08);
         apb(1'b1, REG_ADDR, {13'h0, SEC[i][9:4], 13'h0});
         apb(1'b0, REG_SECTOR, 32'h0);
         chk("sector", {28'h0, SEC[i][3:0]}, rd);
      end
   endtask : t_sector
   task t_reset;
      op(32'hE, 32'h0, 32'h1B);
      op(32'hE, 32'h0, 32'h1D);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("ready", 32'h2, rd & 32'h2);
      op(32'hE, 32'h0, 32'h19);
      chk("array", 32'h0, rd & 32'hFFFF);
      // software programs 00C3 at the address whose program the reset cut short
      op(32'hE, 32'h00C3, 32'h1B);
      poll(STAT_RDY, 1'b1);
      op(32'hE, 32'h0, 32'h19);
      chk("restart", 32'h00C3, rd & 32'hFFFF);
   endtask : t_reset
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_blank();
      t_word();
      t_byte();
      t_sector();
      t_reset();
      end_sim();
   end
   initial begin
      #200000;
      fails++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
